//--- logic/radio_trim_gain_config_regs.sv
// Radio trim and gain configuration register bank with AHB-Lite slave
module radio_trim_gain_config_regs (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Radio sequencer side
    input wire logic fsm_xtal_pd,
    input wire logic tx_request,
    input wire logic rx_request,
    input wire logic cal_done,
    output logic cal_start,
    output logic tx_go,
    output logic rx_go,
    output logic cal_busy,
    // Analog configuration
    output logic xtal_lowfreq_pd,
    output logic [7:0] test_pattern,
    output logic test_pattern_active,
    output radio_cfg_pkg::gain_cfg_type gain_cfg,
    output radio_cfg_pkg::trim_cfg_type trim_cfg
);

    // ------------------------------------------------------------
    // Address phase capture
    // ------------------------------------------------------------
    radio_cfg_pkg::bus_req_type req;
    radio_cfg_pkg::bus_req_type next_req;
    logic read_wait;
    logic addr_take;
    logic addr_good;

    assign addr_take = hsel && hready && htrans[radio_cfg_pkg::HTRANS_ACTIVE_BIT];
    // Only aligned whole words are decoded; anything else is ignored and reads zero
    assign addr_good = (hsize == radio_cfg_pkg::HSIZE_WORD) && (haddr[1:0] == 2'h0)
                       && (haddr[31:10] == 22'h00_0000);
    assign next_req.valid = addr_take;
    assign next_req.write = hwrite;
    assign next_req.good = addr_good;
    assign next_req.index = haddr[9:2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
        end else if (hready) begin
            req <= next_req;
        end
    end

    // Reads take one wait state so a preceding write is always seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            read_wait <= 1'b0;
        end else begin
            read_wait <= req.valid && !req.write && !read_wait;
        end
    end

    assign hreadyout = !(req.valid && !req.write && !read_wait);
    assign hresp = 1'b0;

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    logic wr_commit;
    logic wr_fine_gain;
    logic wr_gain_loop;

    assign wr_commit = req.valid && req.write && req.good;
    assign wr_fine_gain = wr_commit && (req.index == radio_cfg_pkg::FINE_GAIN_CTRL_EXT_INDEX);
    assign wr_gain_loop = wr_commit && (req.index == radio_cfg_pkg::GAIN_LOOP_CTRL_INDEX);

    // ------------------------------------------------------------
    // Word registers
    // ------------------------------------------------------------
    logic [31:0] fine_gain_ctrl_ext;
    logic [31:0] gain_loop_ctrl;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fine_gain_ctrl_ext <= radio_cfg_pkg::FINE_GAIN_CTRL_EXT_RESET;
        end else if (wr_fine_gain) begin
            fine_gain_ctrl_ext <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gain_loop_ctrl <= radio_cfg_pkg::GAIN_LOOP_CTRL_RESET;
        end else if (wr_gain_loop) begin
            gain_loop_ctrl <= hwdata;
        end
    end

    // ------------------------------------------------------------
    // Trim registers
    // ------------------------------------------------------------
    logic [6:0] trim_value [radio_cfg_pkg::TRIM_COUNT];
    logic [radio_cfg_pkg::TRIM_COUNT-1:0] trim_hit;

    for (genvar i = 0; i < radio_cfg_pkg::TRIM_COUNT; i++) begin : g_trim
        assign trim_hit[i] = req.good && (req.index == radio_cfg_pkg::TRIM_INDEX[i]);
        trim_field #(
            .RESET_VALUE(radio_cfg_pkg::TRIM_RESET[i])
        ) u_trim (
            .hclk(hclk),
            .hresetn(hresetn),
            .write_en(wr_commit && trim_hit[i]),
            .write_data(hwdata[7:0]),
            .value(trim_value[i])
        );
    end

    assign trim_cfg.dac_trim_lower = trim_value[0];
    assign trim_cfg.dac_trim_upper = trim_value[radio_cfg_pkg::TRIM_UPPER_SLOT];
    assign trim_cfg.dc_offset_i = trim_value[2];
    assign trim_cfg.dc_offset_q = trim_value[3];

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [31:0] read_mux;

    always_comb begin
        read_mux = 32'h0000_0000;
        if (!req.good) begin
            read_mux = 32'h0000_0000;
        end else if (req.index == radio_cfg_pkg::FINE_GAIN_CTRL_EXT_INDEX) begin
            read_mux = fine_gain_ctrl_ext;
        end else if (req.index == radio_cfg_pkg::GAIN_LOOP_CTRL_INDEX) begin
            read_mux = gain_loop_ctrl;
        end else if (trim_hit[0]) begin
            read_mux = {25'h000_0000, trim_value[0]};
        end else if (trim_hit[1]) begin
            read_mux = {25'h000_0000, trim_value[1]};
        end else if (trim_hit[2]) begin
            read_mux = {25'h000_0000, trim_value[2]};
        end else if (trim_hit[3]) begin
            read_mux = {25'h000_0000, trim_value[3]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (req.valid && !req.write && !read_wait) begin
            hrdata <= read_mux;
        end
    end

    // ------------------------------------------------------------
    // Gain configuration fields
    // ------------------------------------------------------------
    localparam int RA = radio_cfg_pkg::PEAK_REF_A_LSB;
    localparam int RB = radio_cfg_pkg::PEAK_REF_B_LSB;
    localparam int LT = radio_cfg_pkg::PEAK_LOW_THR_LSB;
    localparam int RC = radio_cfg_pkg::GAIN_RESET_COUNT_LSB;
    localparam int AS = radio_cfg_pkg::ANALOG_SAMPLE_MODE_LSB;
    localparam int DS = radio_cfg_pkg::DIGITAL_SAMPLE_MODE_LSB;
    localparam int BO = radio_cfg_pkg::PEAK_BACKOFF_LSB;
    localparam int PT = radio_cfg_pkg::PEAK_THR_LSB;

    assign gain_cfg.peak_det_ref_a = fine_gain_ctrl_ext[RA+2:RA];
    assign gain_cfg.peak_det_ref_b = fine_gain_ctrl_ext[RB+1:RB];
    // Low level picks the first loop variant
    assign gain_cfg.gain_loop_select =
        fine_gain_ctrl_ext[radio_cfg_pkg::GAIN_LOOP_SELECT_BIT];
    assign gain_cfg.digital_peak_low_threshold = fine_gain_ctrl_ext[LT+10:LT];
    assign gain_cfg.gain_reset_count = fine_gain_ctrl_ext[RC+11:RC];
    assign gain_cfg.analog_sample_mode = gain_loop_ctrl[AS+2:AS];
    assign gain_cfg.digital_sample_mode = gain_loop_ctrl[DS+1:DS];
    assign gain_cfg.peak_max_mode = gain_loop_ctrl[radio_cfg_pkg::PEAK_MODE_BIT];
    assign gain_cfg.peak_backoff_db = gain_loop_ctrl[BO+5:BO];
    assign gain_cfg.peak_threshold = gain_loop_ctrl[PT+10:PT];

    // ------------------------------------------------------------
    // Crystal power-down and analog test pattern
    // ------------------------------------------------------------
    localparam int TW = radio_cfg_pkg::TEST_WORD_LSB;
    logic xtal_pd_source;
    logic next_xtal_pd;
    logic test_enable;

    assign xtal_pd_source = fine_gain_ctrl_ext[radio_cfg_pkg::XTAL_PD_SOURCE_BIT];
    assign next_xtal_pd = xtal_pd_source
                          ? fine_gain_ctrl_ext[radio_cfg_pkg::XTAL_PD_VALUE_BIT]
                          : fsm_xtal_pd;
    assign test_enable = gain_loop_ctrl[radio_cfg_pkg::TEST_ENABLE_BIT];

    // Registered so the analog pins never see a decode glitch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xtal_lowfreq_pd <= 1'b0;
            test_pattern <= 8'h00;
            test_pattern_active <= 1'b0;
        end else begin
            xtal_lowfreq_pd <= next_xtal_pd;
            test_pattern <= test_enable ? gain_loop_ctrl[TW+7:TW] : 8'h00;
            test_pattern_active <= test_enable;
        end
    end

    // ------------------------------------------------------------
    // Start sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        seq_idle,
        seq_cal,
        seq_go
    } seq_state_type;

    seq_state_type state;
    seq_state_type next_state;
    logic going_tx;
    logic cal_each;
    logic any_request;

    assign cal_each = fine_gain_ctrl_ext[radio_cfg_pkg::CAL_EACH_TRANSFER_BIT];
    assign any_request = tx_request || rx_request;

    always_comb begin
        next_state = state;
        case (state)
            seq_idle: begin
                if (any_request) begin
                    next_state = cal_each ? seq_cal : seq_go;
                end
            end
            seq_cal: begin
                if (cal_done) begin
                    next_state = seq_go;
                end
            end
            seq_go: begin
                next_state = seq_idle;
            end
            default: begin
                next_state = seq_idle;
            end
        endcase
    end

    // Requests while a start is in flight are dropped; TX wins a tie
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= seq_idle;
            going_tx <= 1'b0;
        end else begin
            state <= next_state;
            if (state == seq_idle && any_request) begin
                going_tx <= tx_request;
            end
        end
    end

    assign cal_start = (state == seq_idle) && any_request && cal_each;
    assign cal_busy = (state == seq_cal);
    assign tx_go = (state == seq_go) && going_tx;
    assign rx_go = (state == seq_go) && !going_tx;

endmodule : radio_trim_gain_config_regs

//--- logic/trim_field.sv
// One 7-bit trim value with write-one restore on bit 7
module trim_field #(
    parameter logic [6:0] RESET_VALUE = 7'h00
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Write port
    input wire logic write_en,
    input wire logic [7:0] write_data,
    // Trim value
    output logic [6:0] value
);

    logic [6:0] next_value;

    assign next_value = write_data[radio_cfg_pkg::TRIM_RESTORE_BIT] ? RESET_VALUE
                                                                     : write_data[6:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            value <= RESET_VALUE;
        end else if (write_en) begin
            value <= next_value;
        end
    end

endmodule : trim_field

//--- shared/radio_cfg_pkg.sv
// Constants, field layout and carrier types for the radio trim and gain register bank
package radio_cfg_pkg;

    // ------------------------------------------------------------
    // Register indexes (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] FINE_GAIN_CTRL_EXT_INDEX = 8'h13;
    localparam logic [7:0] DAC_TRIM_LOWER_INDEX = 8'h17;
    localparam logic [7:0] DAC_TRIM_UPPER_INDEX = 8'h18;
    localparam logic [7:0] DC_OFFSET_I_INDEX = 8'h1a;
    localparam logic [7:0] DC_OFFSET_Q_INDEX = 8'h1b;
    localparam logic [7:0] GAIN_LOOP_CTRL_INDEX = 8'h1c;

    // ------------------------------------------------------------
    // Trim registers
    // ------------------------------------------------------------
    localparam int TRIM_COUNT = 4;
    localparam int TRIM_RESTORE_BIT = 7;
    localparam logic [7:0] TRIM_INDEX [TRIM_COUNT] = '{
        DAC_TRIM_LOWER_INDEX, DAC_TRIM_UPPER_INDEX, DC_OFFSET_I_INDEX, DC_OFFSET_Q_INDEX
    };
    localparam logic [6:0] TRIM_RESET [TRIM_COUNT] = '{7'h00, 7'h7f, 7'h00, 7'h00};
    localparam int TRIM_UPPER_SLOT = 1;

    // ------------------------------------------------------------
    // Extended fine gain control fields
    // ------------------------------------------------------------
    localparam logic [31:0] FINE_GAIN_CTRL_EXT_RESET = 32'h2908_1400;
    localparam int XTAL_PD_VALUE_BIT = 31;
    localparam int XTAL_PD_SOURCE_BIT = 30;
    localparam int CAL_EACH_TRANSFER_BIT = 29;
    localparam int PEAK_REF_A_LSB = 26;
    localparam int PEAK_REF_B_LSB = 24;
    localparam int GAIN_LOOP_SELECT_BIT = 23;
    localparam int PEAK_LOW_THR_LSB = 12;
    localparam int GAIN_RESET_COUNT_LSB = 0;

    // ------------------------------------------------------------
    // Gain loop control fields
    // ------------------------------------------------------------
    localparam logic [31:0] GAIN_LOOP_CTRL_RESET = 32'h0009_08c8;
    localparam int TEST_WORD_LSB = 24;
    localparam int TEST_ENABLE_BIT = 23;
    localparam int ANALOG_SAMPLE_MODE_LSB = 20;
    localparam int DIGITAL_SAMPLE_MODE_LSB = 18;
    localparam int PEAK_MODE_BIT = 17;
    localparam int PEAK_BACKOFF_LSB = 11;
    localparam int PEAK_THR_LSB = 0;

    // ------------------------------------------------------------
    // Bus encodings
    // ------------------------------------------------------------
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int HTRANS_ACTIVE_BIT = 1;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic good;
        logic [7:0] index;
    } bus_req_type;

    typedef struct packed {
        logic [2:0] peak_det_ref_a;
        logic [1:0] peak_det_ref_b;
        logic gain_loop_select;
        logic [10:0] digital_peak_low_threshold;
        logic [11:0] gain_reset_count;
        logic [2:0] analog_sample_mode;
        logic [1:0] digital_sample_mode;
        logic peak_max_mode;
        logic [5:0] peak_backoff_db;
        logic [10:0] peak_threshold;
    } gain_cfg_type;

    typedef struct packed {
        logic [6:0] dac_trim_lower;
        logic [6:0] dac_trim_upper;
        logic [6:0] dc_offset_i;
        logic [6:0] dc_offset_q;
    } trim_cfg_type;

endpackage : radio_cfg_pkg

//--- test/radio_trim_gain_config_regs_bench.sv
// Self-checking bench for the radio trim and gain register bank
module radio_trim_gain_config_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] FINE = 32'h0000_004c;
    localparam logic [31:0] LOOP = 32'h0000_0070;
    localparam logic [31:0] XT_WORD [5] = '{32'he908_1400, 32'h6908_1400,
        32'h2908_1400, 32'h2908_1400, 32'ha908_1400};
    localparam logic [1:0] XT_IO [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
    logic hclk = '0;
    logic hresetn = '0;
    logic hsel = '0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = '0;
    logic [2:0] hsize = '0;
    logic [31:0] hwdata = '0;
    logic fsm_xtal_pd = '0;
    logic tx_request = '0;
    logic rx_request = '0;
    logic cal_done = '0;
    logic [31:0] hrdata;
    logic hreadyout, cal_start, tx_go, rx_go, cal_busy, xtal_lowfreq_pd, test_pattern_active;
    logic [7:0] test_pattern;
    radio_cfg_pkg::gain_cfg_type gain_cfg;
    radio_cfg_pkg::trim_cfg_type trim_cfg;
    logic [15:0] seed = 16'h0993; // Decimal 2451
    int failures = 0;
    int checks_done = 0;

    radio_trim_gain_config_regs DUT (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .fsm_xtal_pd, .tx_request,
        .rx_request, .cal_done, .cal_start, .tx_go, .rx_go, .cal_busy, .xtal_lowfreq_pd,
        .test_pattern, .test_pattern_active, .gain_cfg, .trim_cfg
    );

    initial forever #20 hclk = ~hclk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic [31:0] tadr(input int j);
        return {22'h00_0000, radio_cfg_pkg::TRIM_INDEX[j], 2'h0};
    endfunction : tadr

    function automatic logic [6:0] trim_exp(input int j, input logic [7:0] b);
        return b[7] ? radio_cfg_pkg::TRIM_RESET[j] : b[6:0];
    endfunction : trim_exp

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    // Bounded, so a stuck slave ends the run instead of hanging it
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: bus hang", $time);
            wrap_up();
        end
    endtask : wait_ready

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        hsize <= 3'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        check(hrdata, e);
    endtask : rd

    task automatic start_xfer(input logic tx, input logic cal);
        tx_request <= tx;
        rx_request <= !tx;
        @(posedge hclk);
        check(cal_start, cal);
        tx_request <= 1'b0;
        rx_request <= 1'b0;
        if (cal) begin
            repeat (3) begin
                @(posedge hclk);
                check({tx_go, rx_go, cal_busy}, 3'h1);
            end
            cal_done <= 1'b1;
            @(posedge hclk);
            cal_done <= 1'b0;
        end
        @(posedge hclk);
        check({tx_go, rx_go}, {tx, !tx});
    endtask : start_xfer

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [6:0] cur [4];
        int k;
        int j;
        cur = radio_cfg_pkg::TRIM_RESET;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check(gain_cfg.gain_loop_select, 1'b0);
        rd(FINE, 32'h2908_1400);
        rd(LOOP, 32'h0009_08c8);
        for (k = 0; k < 4; k++) begin
            rd(tadr(k), {25'h000_0000, cur[k]});
        end
        for (k = 0; k < 16; k++) begin
            seed = lfsr(seed);
            j = seed[9:8];
            wr(tadr(j), {24'h00_0000, seed[7:0]});
            cur[j] = trim_exp(j, seed[7:0]);
            rd(tadr(j), {25'h000_0000, cur[j]});
        end
        wr(tadr(1), 32'h0000_0005);
        wr(tadr(1), 32'h0000_0080);
        cur[1] = 7'h7f;
        rd(tadr(1), 32'h0000_007f);
        check(trim_cfg, {cur[0], cur[1], cur[2], cur[3]});
        // Unmapped place swallows writes and reads zero
        wr(32'h0000_0074, 32'hffff_ffff);
        rd(32'h0000_0074, 32'h0000_0000);
        for (k = 0; k < 5; k++) begin
            wr(FINE, XT_WORD[k]);
            fsm_xtal_pd <= XT_IO[k][1];
            repeat (2) @(posedge hclk);
            check(xtal_lowfreq_pd, XT_IO[k][0]);
        end
        wr(FINE, 32'h2988_1400);
        rd(FINE, 32'h2988_1400);
        check(gain_cfg.gain_loop_select, 1'b1);
        wr(LOOP, 32'ha589_08c8);
        repeat (2) @(posedge hclk);
        check({test_pattern_active, test_pattern}, 9'h1a5);
        wr(LOOP, 32'ha509_08c8);
        repeat (2) @(posedge hclk);
        check({test_pattern_active, test_pattern}, 9'h000);
        for (k = 0; k < 4; k++) begin
            wr(FINE, {2'h0, k[1], 29'h0908_1400});
            start_xfer(k[0], k[1]);
        end
        wrap_up();
    end
endmodule : radio_trim_gain_config_regs_bench

//--- test/radio_trim_gain_config_regs_props.sv
// Property checker for the radio trim and gain register bank
module radio_cfg_checker (
    // Bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // Clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // Sequencer side
    input wire logic fsm_xtal_pd,
    input wire logic tx_request,
    input wire logic rx_request,
    input wire logic cal_done,
    input wire logic cal_start,
    input wire logic tx_go,
    input wire logic rx_go,
    input wire logic cal_busy,
    // Analog side
    input wire logic xtal_lowfreq_pd,
    input wire logic [7:0] test_pattern,
    input wire logic test_pattern_active,
    input wire radio_cfg_pkg::gain_cfg_type gain_cfg,
    input wire radio_cfg_pkg::trim_cfg_type trim_cfg
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Shadow of bits 31:29, so no probes into the design are needed
    // ------------------------------------------------------------
    logic take;
    logic wr_fine;
    logic wr_upper;
    logic xtal_want;
    logic [2:0] fine_top;
    assign take = hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
    assign xtal_want = fine_top[1] ? fine_top[2] : fsm_xtal_pd;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_fine <= 1'b0;
            wr_upper <= 1'b0;
            fine_top <= 3'h1;
        end else begin
            wr_fine <= take && haddr == 32'h0000_004c;
            wr_upper <= take && haddr == 32'h0000_0060;
            if (wr_fine)
                fine_top <= hwdata[31:29];
        end
    end
    default clocking dc @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    AST_XTAL_SOURCE: assert property (xtal_lowfreq_pd == $past(xtal_want))
        else $error("crystal power-down source wrong");
    AST_CAL_CAUSE: assert property (
        cal_start |-> fine_top[0] && (tx_request || rx_request))
        else $error("calibration start without cause");
    AST_CAL_BUSY: assert property (cal_start |=> cal_busy)
        else $error("calibration not busy after start");
    AST_GO_AFTER_DONE: assert property (
        cal_busy && cal_done |=> (tx_go || rx_go) && !cal_busy)
        else $error("no start pulse after calibration");
    AST_DIRECT_GO: assert property (
        (tx_request || rx_request) && !fine_top[0] && !cal_busy && !tx_go && !rx_go
        |=> tx_go || rx_go) else $error("direct start missing");
    AST_TRIM_KEEP: assert property (
        wr_upper && !hwdata[7] |=> trim_cfg.dac_trim_upper == $past(hwdata[6:0]))
        else $error("trim value not loaded");
    AST_TRIM_RESTORE: assert property (
        wr_upper && hwdata[7] |=> trim_cfg.dac_trim_upper == 7'h7f)
        else $error("trim not restored");
    AST_GAIN_SELECT: assert property (
        wr_fine |=> gain_cfg.gain_loop_select == $past(hwdata[23]))
        else $error("gain loop select wrong");
    AST_TEST_OFF: assert property (!test_pattern_active |-> test_pattern == 8'h00)
        else $error("test pattern leaks while disabled");
    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    AST_ONE_WAIT: assert property (!hreadyout |=> hreadyout)
        else $error("bus wait longer than one cycle");
    cover property (cal_start);
    cover property (wr_upper && hwdata[7]);
    cover property (tx_go && !fine_top[0]);
endmodule : radio_cfg_checker

bind radio_trim_gain_config_regs radio_cfg_checker checker_inst (
    .hreadyout, .hresp,
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .fsm_xtal_pd, .tx_request, .rx_request, .cal_done, .cal_start, .tx_go, .rx_go,
    .cal_busy, .xtal_lowfreq_pd, .test_pattern, .test_pattern_active, .gain_cfg, .trim_cfg
);
